// File: rtl/wd_pkg.sv
// Constants, register map and field layout of the system watchdog.
// Assumes a single 200 MHz clock and a sampled low-frequency oscillator.
//
// Summary of operation
// - Time-out while awake raises system reset
// - Counter advances only on slow oscillator edges
// - Mode field 00 keeps watchdog off
// - Mode 11 runs always, sleep included
// - Mode 10 runs awake, off in sleep
// - Mode 01 follows the software enable bit
// - Period select picks 1 ms to 256 s
// - Reset restores period select to 2 s
// - Reset, clear instruction, disabling clear counter
// - Sleep entry and wake both clear counter
// - Osc failure and start-up timer clear counter
// - Time-out in sleep wakes, no reset
// - Ratios double per step; reserved codes minimum
// - Period bits 5:1, enable bit 0, 7:6 zero
package wd_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PS_W   = 5;
  localparam int CNT_W  = 23;

  // Nominal slow oscillator rate, kept for reference of intervals
  localparam int LFO_FREQ_HZ = 31000;
  localparam int CLK_FREQ_HZ = 200000000;

  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_EVENTS  = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_MASK    = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_STATE   = 4'h3;

  localparam int SWEN_BIT = 0;
  localparam int PS_LSB   = 1;
  localparam int PS_MSB   = 5;

  localparam logic [PS_W-1:0] PS_RESET   = 5'h0B;
  localparam logic [PS_W-1:0] PS_MAX     = 5'h12;
  localparam logic [PS_W-1:0] PS_MIN     = 5'h00;
  localparam logic            SWEN_RESET = 1'b0;
  localparam int              TAP_BASE   = 5;

  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_SW     = 2'h1;
  localparam logic [1:0] MODE_AWAKE  = 2'h2;
  localparam logic [1:0] MODE_ALWAYS = 2'h3;

  localparam int EV_W        = 2;
  localparam int EV_RESET    = 0;
  localparam int EV_WAKE     = 1;
  localparam int ST_ACTIVE   = 0;
  localparam int ST_ASLEEP   = 1;
  localparam int ST_HELD     = 2;

  typedef enum logic {
    PWR_AWAKE,
    PWR_ASLEEP
  } pwr_t;

endpackage : wd_pkg

// File: rtl/wd_prescaler.sv
// Free-running binary prescaler for the watchdog time base.
// Assumes tick_i is a one-cycle pulse per slow oscillator period.
`timescale 1ns/1ps
`default_nettype none
module wd_prescaler #(
  parameter int CNT_W = 23
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             tick_i,
  input  wire logic             clear_i,
  input  wire logic [CNT_W-1:0] limit_i,
  output logic      [CNT_W-1:0] count_o,
  output logic                  expire_o
);

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;

  // Expiry on the tick at or past the chosen tap; a shortened period
  // must still fire rather than wait for the counter to wrap
  assign expire_o = tick_i && !clear_i && (count_r >= limit_i);
  assign count_o  = count_r;

  always_comb begin
    count_nxt = count_r;
    if (clear_i) begin
      count_nxt = '0;
    end else if (expire_o) begin
      count_nxt = '0;
    end else if (tick_i) begin
      count_nxt = count_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule : wd_prescaler
`default_nettype wire

// File: rtl/system_watchdog_timer.sv
// Watchdog timer: mode decode, clearing, time-out, registers, interrupt.
// Assumes all inputs synchronous to clk_i; the CPU core drives the
// clear pulse and sleep level, the clock unit the oscillator status.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module system_watchdog_timer #(
  parameter int CNT_W = wd_pkg::CNT_W
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic [1:0]                wd_mode_cfg_i,
  input  wire logic                      low_freq_internal_osc_i,
  input  wire logic                      clear_watchdog_instr_i,
  input  wire logic                      sleep_i,
  input  wire logic                      osc_fail_i,
  input  wire logic                      osc_startup_timer_i,
  input  wire logic [wd_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [wd_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [wd_pkg::DATA_W-1:0] rd_data_o,
  output logic                           wd_reset_o,
  output logic                           wake_o,
  output logic                           irq_o
);

  // Time-out limit for a period code; reserved codes act as the shortest
  function automatic logic [CNT_W-1:0] limit_of(input logic [wd_pkg::PS_W-1:0] ps);
    logic [CNT_W:0] one;
    logic [wd_pkg::PS_W-1:0] code;
    one  = {{CNT_W{1'b0}}, 1'b1};
    code = (ps > wd_pkg::PS_MAX) ? wd_pkg::PS_MIN : ps;
    // 1:32 at code 0, doubling with each step
    limit_of = CNT_W'((one << (wd_pkg::TAP_BASE + int'(code))) - one);
  endfunction : limit_of

  logic [wd_pkg::PS_W-1:0]   period_select_r;
  logic                      sw_watchdog_enable_r;
  logic [wd_pkg::EV_W-1:0]   events_r;
  logic [wd_pkg::EV_W-1:0]   mask_r;
  logic [wd_pkg::DATA_W-1:0] rd_data_r;
  logic                      wd_reset_r;
  logic                      wake_r;
  logic                      irq_r;
  logic                      osc_prev_r;
  wd_pkg::pwr_t              pwr_r;

  logic                      osc_tick;
  logic                      asleep;
  logic                      sleep_edge;
  logic                      active;
  logic                      held_clear;
  logic                      cnt_clear;
  logic [CNT_W-1:0]          limit;
  logic [CNT_W-1:0]          count;
  logic                      expire;
  logic [wd_pkg::EV_W-1:0]   ev_set;
  logic [wd_pkg::EV_W-1:0]   ev_clr;
  logic [wd_pkg::DATA_W-1:0] rd_nxt;

  // Slow oscillator edge; only this advances the counter
  assign osc_tick = low_freq_internal_osc_i && !osc_prev_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= low_freq_internal_osc_i;
    end
  end

  // Power state tracker, used to see sleep entry and wake
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_r <= wd_pkg::PWR_AWAKE;
    end else begin
      pwr_r <= sleep_i ? wd_pkg::PWR_ASLEEP : wd_pkg::PWR_AWAKE;
    end
  end

  assign asleep     = sleep_i;
  assign sleep_edge = (pwr_r == wd_pkg::PWR_ASLEEP) != sleep_i;

  always_comb begin
    case (wd_mode_cfg_i)
      wd_pkg::MODE_ALWAYS: active = 1'b1;
      wd_pkg::MODE_AWAKE:  active = !asleep;
      wd_pkg::MODE_SW:     active = sw_watchdog_enable_r;
      wd_pkg::MODE_OFF:    active = 1'b0;
      default:             active = 1'b0;
    endcase
  end

  // Start-up timer holds the count at zero for its whole run
  assign held_clear = osc_fail_i || osc_startup_timer_i;

  assign cnt_clear = !active
                  || clear_watchdog_instr_i
                  || sleep_edge
                  || held_clear;

  assign limit = limit_of(period_select_r);

  wd_prescaler #(
    .CNT_W (CNT_W)
  ) u_prescaler (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .tick_i   (osc_tick),
    .clear_i  (cnt_clear),
    .limit_i  (limit),
    .count_o  (count),
    .expire_o (expire)
  );

  // Time-out while awake resets; asleep it only wakes the core
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wd_reset_r <= 1'b0;
      wake_r     <= 1'b0;
    end else begin
      wd_reset_r <= expire && !asleep;
      wake_r     <= expire && asleep;
    end
  end

  // Control register; period select and enable steer the counter
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      period_select_r      <= wd_pkg::PS_RESET;
      sw_watchdog_enable_r <= wd_pkg::SWEN_RESET;
    end else if (wr_i && addr_i == wd_pkg::OFS_CONTROL) begin
      period_select_r      <= wr_data_i[wd_pkg::PS_MSB:wd_pkg::PS_LSB];
      sw_watchdog_enable_r <= wr_data_i[wd_pkg::SWEN_BIT];
    end
  end

  // Event flags: hardware set wins over a same-cycle write of one
  assign ev_set = {expire && asleep, expire && !asleep};
  assign ev_clr = (wr_i && addr_i == wd_pkg::OFS_EVENTS)
                ? wr_data_i[wd_pkg::EV_W-1:0] : '0;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      events_r <= '0;
    end else begin
      events_r <= (events_r & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_r <= '0;
    end else if (wr_i && addr_i == wd_pkg::OFS_MASK) begin
      mask_r <= wr_data_i[wd_pkg::EV_W-1:0];
    end
  end

  // Registered so the output carries no decode glitch
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(((events_r & ~ev_clr) | ev_set) & mask_r);
    end
  end

  // Read mux; unmapped offsets and unused upper bits read zero
  always_comb begin
    rd_nxt = '0;
    case (addr_i)
      wd_pkg::OFS_CONTROL: begin
        rd_nxt[wd_pkg::PS_MSB:wd_pkg::PS_LSB] = period_select_r;
        rd_nxt[wd_pkg::SWEN_BIT]              = sw_watchdog_enable_r;
      end
      wd_pkg::OFS_EVENTS: begin
        rd_nxt[wd_pkg::EV_W-1:0] = events_r;
      end
      wd_pkg::OFS_MASK: begin
        rd_nxt[wd_pkg::EV_W-1:0] = mask_r;
      end
      wd_pkg::OFS_STATE: begin
        rd_nxt[wd_pkg::ST_ACTIVE] = active;
        rd_nxt[wd_pkg::ST_ASLEEP] = asleep;
        rd_nxt[wd_pkg::ST_HELD]   = held_clear;
      end
      default: begin
        rd_nxt = '0;
      end
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= rd_i ? rd_nxt : '0;
    end
  end

  assign rd_data_o  = rd_data_r;
  assign wd_reset_o = wd_reset_r;
  assign wake_o     = wake_r;
  assign irq_o      = irq_r;

  // Checks below tie each output or count to its cause

  a_reset_on_expire: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (expire && !sleep_i) |=> (wd_reset_o && !wake_o)
  ) else $error("time-out while awake gave no reset");

  a_no_spurious_reset: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !$past(expire) |-> !wd_reset_o
  ) else $error("reset without a time-out");

  a_wake_in_sleep: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (expire && sleep_i) |=> (wake_o && !wd_reset_o)
  ) else $error("time-out in sleep did not wake");

  a_off_mode_quiet: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wd_mode_cfg_i == wd_pkg::MODE_OFF) |-> ##1 (count == '0) && !expire
  ) else $error("counter ran with the mode field off");

  a_sleep_stops_awake_mode: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wd_mode_cfg_i == wd_pkg::MODE_AWAKE && sleep_i) [*2] |-> (count == '0)
  ) else $error("awake-only mode counted in sleep");

  a_always_runs: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wd_mode_cfg_i == wd_pkg::MODE_ALWAYS && osc_tick && !cnt_clear
      && count < limit) |=> (count == $past(count) + 1'b1)
  ) else $error("always-on mode did not count");

  a_sw_enable_gate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wd_mode_cfg_i == wd_pkg::MODE_SW && !sw_watchdog_enable_r)
      |=> (count == '0) && !wd_reset_o
  ) else $error("software mode ignores the enable bit");

  a_clear_instr: assert property (
    @(posedge clk_i) disable iff (rst_i)
    clear_watchdog_instr_i |=> (count == '0)
  ) else $error("clear instruction left the counter");

  a_sleep_edges_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ($rose(sleep_i) || $fell(sleep_i)) |=> (count == '0)
  ) else $error("sleep entry or wake did not clear");

  a_ost_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (osc_startup_timer_i || osc_fail_i) |=> (count == '0)
  ) else $error("count moved under oscillator hold");

  a_count_on_tick: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!osc_tick && !cnt_clear) |=> (count == $past(count))
  ) else $error("counter moved without an oscillator edge");

  a_reserved_min: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (period_select_r > wd_pkg::PS_MAX) |-> (limit == CNT_W'(31))
  ) else $error("reserved period code not minimum");

  a_restart_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    expire |=> (count == '0) ##0 wd_reset_o || wake_o
  ) else $error("counter did not restart after time-out");

  a_ctrl_top_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == wd_pkg::OFS_CONTROL) |=>
      (rd_data_o[wd_pkg::DATA_W-1:wd_pkg::PS_MSB+1] == '0)
      && (rd_data_o[wd_pkg::PS_MSB:wd_pkg::PS_LSB] == $past(period_select_r))
  ) else $error("control read back wrong");

  a_irq_level: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 (irq_o == |$past((events_r & ~ev_clr | ev_set) & mask_r))
  ) else $error("interrupt does not follow masked events");

  a_expire_needs_tick: assert property (
    @(posedge clk_i) disable iff (rst_i)
    expire |-> (osc_tick && !cnt_clear)
  ) else $error("time-out without an oscillator edge");

  a_tap_reached: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (osc_tick && !cnt_clear && count >= limit) |-> expire
  ) else $error("chosen tap reached but no time-out");

  a_limit_span: assert property (
    @(posedge clk_i) disable iff (rst_i)
    limit[wd_pkg::TAP_BASE-1:0] == '1
  ) else $error("limit shorter than the minimum interval");

  a_wake_only_asleep: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wake_o |-> $past(sleep_i)
  ) else $error("wake pulse while awake");

  a_reset_single: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wd_reset_o |=> !wd_reset_o
  ) else $error("reset pulse longer than one cycle");

  a_off_mode_silent: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wd_mode_cfg_i == wd_pkg::MODE_OFF) |=> (!wd_reset_o && !wake_o)
  ) else $error("off mode produced a time-out");

  a_awake_mode_asleep: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wd_mode_cfg_i == wd_pkg::MODE_AWAKE && sleep_i) |=> (!wd_reset_o && !wake_o)
  ) else $error("awake-only mode timed out in sleep");

  a_ctrl_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_i && addr_i == wd_pkg::OFS_CONTROL) |=>
      (period_select_r == $past(wr_data_i[wd_pkg::PS_MSB:wd_pkg::PS_LSB]))
      && (sw_watchdog_enable_r == $past(wr_data_i[wd_pkg::SWEN_BIT]))
  ) else $error("control write did not land");

  a_state_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == wd_pkg::OFS_STATE) |=>
      (rd_data_o[wd_pkg::ST_ACTIVE] == $past(active))
      && (rd_data_o[wd_pkg::ST_HELD] == $past(held_clear))
  ) else $error("state read back wrong");

  a_rd_idle_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !rd_i |=> (rd_data_o == '0)
  ) else $error("read data stood past its cycle");

  a_event_set_wins: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ev_set != '0) |=> ((events_r & $past(ev_set)) == $past(ev_set))
  ) else $error("time-out event flag lost");

endmodule : system_watchdog_timer
`default_nettype wire

// File: verification/cpu_core_model.sv
// Model of the CPU core side: slow oscillator, clear pulses, sleep level.
// Assumes the bench raises its requests at rising clock edges.
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  input  wire logic clr_req_i,
  input  wire logic sleep_req_i,
  output logic      osc_o,
  output logic      clear_o,
  output logic      sleep_o
);
  logic [1:0] div_r;

  // One tick every 8 clocks; frozen so clears never race a tick
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r <= 2'h0;
      osc_o <= 1'b0;
    end else if (run_i) begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h3) begin
        osc_o <= ~osc_o;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clear_o <= 1'b0;
      sleep_o <= 1'b0;
    end else begin
      clear_o <= clr_req_i;
      sleep_o <= sleep_req_i;
    end
  end
endmodule : cpu_core_model
`default_nettype wire

// File: verification/system_watchdog_timer_tb.sv
// Self-checking bench for the watchdog: registers, periods, modes, clears.
// Assumes the core model supplies oscillator, clear and sleep.
`timescale 1ns/1ps
`default_nettype none
module system_watchdog_timer_tb;
  logic                      clk_i, rst_i, run, clr_req, sleep_req;
  logic                      osc_w, clr_w, sleep_w, osc_fail_i, ost_i;
  logic [1:0]                wd_mode_cfg_i;
  logic [wd_pkg::ADDR_W-1:0] addr_i;
  logic [wd_pkg::DATA_W-1:0] wr_data_i, rd_data_o;
  logic                      wr_i, rd_i, wd_reset_o, wake_o, irq_o;
  int                        bad_count, n_tests;
  logic [4:0]                codes [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h13, 5'h1F};

  cpu_core_model core (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .clr_req_i(clr_req),
    .sleep_req_i(sleep_req), .osc_o(osc_w), .clear_o(clr_w), .sleep_o(sleep_w));

  system_watchdog_timer dut (.clk_i(clk_i), .rst_i(rst_i), .wd_mode_cfg_i(wd_mode_cfg_i),
    .low_freq_internal_osc_i(osc_w), .clear_watchdog_instr_i(clr_w), .sleep_i(sleep_w),
    .osc_fail_i(osc_fail_i), .osc_startup_timer_i(ost_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .wd_reset_o(wd_reset_o), .wake_o(wake_o), .irq_o(irq_o));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic wrap_up;
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %0h want %0h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(rd_data_o, e, "read data");
  endtask : rd_chk

  task automatic set_cfg(input logic [1:0] md, input logic slp);
    @(posedge clk_i);
    wd_mode_cfg_i <= md;
    sleep_req     <= slp;
    repeat (3) @(posedge clk_i);
  endtask : set_cfg

  // Run pre ticks, clear by source src, then count ticks to the time-out.
  // n of 0 means no time-out may come within 40 ticks.
  task automatic expire(input int n, input logic wk, input int pre, input int src);
    int   t;
    int   lim;
    logic seen, ws, oq;
    // One edge between calls so run and strobes never get two values at once
    @(posedge clk_i);
    if (pre > 0) begin
      run <= 1'b1;
      repeat (pre * 8) @(posedge clk_i);
      run <= 1'b0;
    end
    case (src)
      0: clr_req <= 1'b1;
      1: sleep_req <= ~sleep_req;
      2: osc_fail_i <= 1'b1;
      default: ost_i <= 1'b1;
    endcase
    @(posedge clk_i);
    clr_req    <= 1'b0;
    osc_fail_i <= 1'b0;
    ost_i      <= 1'b0;
    repeat (3) @(posedge clk_i);
    run  <= 1'b1;
    t    = 0;
    seen = 1'b0;
    ws   = 1'b0;
    oq   = osc_w;
    lim  = (n == 0) ? 320 : (n + 4) * 8;
    for (int i = 0; i < lim && !seen; i++) begin
      @(negedge clk_i);
      if (osc_w === 1'b1 && oq === 1'b0) t++;
      if (wd_reset_o === 1'b1 || wake_o === 1'b1) begin
        seen = 1'b1;
        ws   = wake_o;
      end
      oq = osc_w;
    end
    @(posedge clk_i);
    run <= 1'b0;
    chk(seen, n != 0, "time-out seen");
    if (n != 0 && !seen) wrap_up();
    if (seen) begin
      chk(t, n, "ticks to time-out");
      chk(ws, wk, "wake instead of reset");
    end
  endtask : expire

  initial begin
    int e;
    rst_i = 1'b1; run = 1'b0; clr_req = 1'b0; sleep_req = 1'b0;
    osc_fail_i = 1'b0; ost_i = 1'b0; wd_mode_cfg_i = 2'h3; addr_i = 4'h0;
    wr_data_i = 8'h00; wr_i = 1'b0; rd_i = 1'b0; bad_count = 0; n_tests = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(4'h0, 8'h16);
    wr(4'h2, 8'h01);
    rd_chk(4'h2, 8'h01);
    // The reset period is far beyond the run budget; only its absence is seen
    expire(0, 1'b0, 0, 0);
    wr(4'h0, 8'hFF);
    rd_chk(4'h0, 8'h3F);
    rd_chk(4'hF, 8'h00);
    foreach (codes[k]) begin
      e = (codes[k] > 5'h12) ? 32 : (1 << (5 + codes[k]));
      wr(4'h0, {2'b00, codes[k], 1'b0});
      expire(e, 1'b0, 20, 0);
    end
    @(negedge clk_i);
    chk(irq_o, 1'b1, "irq after time-out");
    rd_chk(4'h1, 8'h01);
    wr(4'h1, 8'h03);
    @(negedge clk_i);
    chk(irq_o, 1'b0, "irq after clear");
    expire(32, 1'b0, 20, 2);
    expire(32, 1'b0, 20, 3);
    expire(32, 1'b1, 20, 1);
    rd_chk(4'h1, 8'h03);
    expire(32, 1'b0, 20, 1);
    set_cfg(2'h0, 1'b0);
    expire(0, 1'b0, 0, 0);
    set_cfg(2'h1, 1'b1);
    expire(0, 1'b0, 0, 0);
    wr(4'h0, 8'h27);
    rd_chk(4'h3, 8'h03);
    expire(32, 1'b1, 0, 0);
    set_cfg(2'h2, 1'b1);
    rd_chk(4'h3, 8'h02);
    expire(0, 1'b0, 0, 0);
    set_cfg(2'h2, 1'b0);
    expire(32, 1'b0, 0, 0);
    wrap_up();
  end
endmodule : system_watchdog_timer_tb
`default_nettype wire
